// ===== verilog/pbp_cfg.svh
`ifndef PBP_CFG_SVH
`define PBP_CFG_SVH

// Control word fields
`define PBP_CTL_ON_BIT     15
`define PBP_CTL_RDPOL_BIT  0
`define PBP_CTL_WRPOL_BIT  1
`define PBP_CTL_CS1POL_BIT 3
`define PBP_CTL_CSF_MSB    7
`define PBP_CTL_CSF_LSB    6

// Mode word fields
`define PBP_MODE_BUSY_BIT  15
`define PBP_MODE_IRQM_MSB  14
`define PBP_MODE_IRQM_LSB  13
`define PBP_MODE_ADDRESS_INCREMENT_FIELD_MSB  12
`define PBP_MODE_ADDRESS_INCREMENT_FIELD_LSB  11
`define PBP_MODE_MODE_MSB  9
`define PBP_MODE_MODE_LSB  8

// Field encodings
`define PBP_MODE_LEGACY    2'h0
`define PBP_MODE_ADDRESSED 2'h1
`define PBP_ADDRESS_INCREMENT_FIELD_BUFFERED  2'h3
`define PBP_IRQM_BUF3      2'h2
`define PBP_BUF_FIRST      2'h0
`define PBP_BUF_LAST       2'h3
`define PBP_BUF_STEP       2'h1

// Sizes and counts
`define PBP_BYTE_W         8
`define PBP_WORD_W         32
`define PBP_CTL_W          16
`define PBP_FIFO_DEPTH     16
`define PBP_MASTER_OP_CYC  2'h3
`define PBP_OP_STEP        2'h1

`endif

// ===== verilog/pbp_pkg.sv
package pbp_pkg;

    typedef enum logic [2:0] {
        PBP_IDLE  = 3'b001,
        PBP_WRITE = 3'b010,
        PBP_READ  = 3'b100
    } pbp_acc_t;

    typedef logic [1:0] pbp_sel_t;

endpackage : pbp_pkg

// ===== verilog/pbp_fifo.sv
`timescale 1ns/1ns

module pbp_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wrIdx_r, wrIdx_nxt;
    logic [AW-1:0]    rdIdx_r, rdIdx_nxt;
    logic [AW:0]      count_r, count_nxt;
    logic             outValid_r, outValid_nxt;
    logic [WIDTH-1:0] outData_r, outData_nxt;
    logic             push, pop;

    assign inReady  = (count_r != (AW+1)'(DEPTH));
    assign outValid = outValid_r;
    assign outData  = outData_r;

    always_comb begin
        push         = inValid && inReady;
        pop          = (count_r != '0) && (!outValid_r || outReady);
        wrIdx_nxt    = push ? wrIdx_r + 1'b1 : wrIdx_r;
        rdIdx_nxt    = pop ? rdIdx_r + 1'b1 : rdIdx_r;
        count_nxt    = count_r + (AW+1)'(push) - (AW+1)'(pop);
        outValid_nxt = pop ? 1'b1 : (outReady ? 1'b0 : outValid_r);
        outData_nxt  = pop ? mem_r[rdIdx_r] : outData_r;
    end

    // Storage entries
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge ref_clk) begin
            if (push && wrIdx_r == AW'(i)) begin
                mem_r[i] <= inData;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wrIdx_r    <= '0;
            rdIdx_r    <= '0;
            count_r    <= '0;
            outValid_r <= 1'b0;
            outData_r  <= '0;
        end else begin
            wrIdx_r    <= wrIdx_nxt;
            rdIdx_r    <= rdIdx_nxt;
            count_r    <= count_nxt;
            outValid_r <= outValid_nxt;
            outData_r  <= outData_nxt;
        end
    end

    fifo_bound_a: assert property (@(posedge ref_clk) disable iff (rst)
        count_r <= (AW+1)'(DEPTH)) else $error("fifo count above depth");

endmodule : pbp_fifo

// ===== verilog/pbp_slave_port.sv
`timescale 1ns/1ns
`include "pbp_cfg.svh"

// Operation
// - Mode 00 with increment field not 11 gives legacy single-byte slave
// - Mode 00 with increment field 11 gives buffered slave
// - Mode 01 gives addressable slave
// - One byte per access, eight lines
// - Slave mode owns select, strobes, data pins
// - Polarity bit 1 high, 0 low
// - Master strobes asynchronously; inputs synchronised
// - Buffered mode has four read/write buffers
// - Writes land in input, reads from output
// - Buffers 0..3 from low byte upward
// - Addressable mode samples two address inputs
// - Address value selects matching byte buffer
// - Busy shown at mode status bit 15
// - Chip selects reusable as high address
// - Clearing on bit stops and resets port
// - Interrupt per byte, or buffer 3 only
// - Busy all but last cycle; starts ignored
module pbp_slave_port
    import pbp_pkg::*;
#(
    parameter int FIFO_DEPTH = `PBP_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     rst,
    // Configuration words
    input  wire logic [`PBP_CTL_W-1:0]    portControl,
    input  wire logic [`PBP_CTL_W-1:0]    portMode,
    output logic [`PBP_CTL_W-1:0]         modeStatus,
    // External master pins
    input  wire logic                     chipSelectOne,
    input  wire logic                     readStrobe,
    input  wire logic                     writeStrobe,
    input  wire logic [1:0]               portAddressLines,
    input  wire logic [`PBP_BYTE_W-1:0]   portDataIn,
    output logic [`PBP_BYTE_W-1:0]        portDataOut,
    output logic                          portDataOe,
    output logic                          slaveOwnsPins,
    output logic [1:0]                    highAddressOut,
    // Core side registers
    input  wire logic [`PBP_WORD_W-1:0]   outputDataRegister,
    output logic [`PBP_WORD_W-1:0]        inputDataRegister,
    output logic                          portInterruptFlag,
    output logic                          writeOverflow,
    output pbp_pkg::pbp_acc_t             accessState,
    // Master operation request
    input  wire logic                     masterStart,
    input  wire logic [1:0]               masterAddrHigh,
    // Received byte stream
    output logic                          rxValid,
    input  wire logic                     rxReady,
    output logic [`PBP_BYTE_W+1:0]        rxData
);
    import pbp_pkg::*;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic                   csS1_r, csS2_r, rdS1_r, rdS2_r, wrS1_r, wrS2_r;
    logic [1:0]             adS1_r, adS2_r;
    logic [`PBP_BYTE_W-1:0] dS1_r, dS2_r;

    always_ff @(posedge ref_clk) begin
        csS1_r <= chipSelectOne;
        csS2_r <= csS1_r;
        rdS1_r <= readStrobe;
        rdS2_r <= rdS1_r;
        wrS1_r <= writeStrobe;
        wrS2_r <= wrS1_r;
        adS1_r <= portAddressLines;
        adS2_r <= adS1_r;
        dS1_r  <= portDataIn;
        dS2_r  <= dS1_r;
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic                   on_r, on_nxt;
    logic [1:0]             mode_r, mode_nxt, address_increment_field_r, address_increment_field_nxt, irqm_r, irqm_nxt, csf_r, csf_nxt;
    logic                   rdPol_r, rdPol_nxt, wrPol_r, wrPol_nxt, csPol_r, csPol_nxt;
    pbp_acc_t               state_r, state_nxt;
    pbp_sel_t               accSel_r, accSel_nxt, rdPtr_r, rdPtr_nxt, wrPtr_r, wrPtr_nxt;
    logic [`PBP_BYTE_W-1:0] wrByte_r, wrByte_nxt, dataOut_r, dataOut_nxt;
    logic [`PBP_WORD_W-1:0] inData_r, inData_nxt;
    logic                   oe_r, oe_nxt, intFlag_r, intFlag_nxt, ovf_r, ovf_nxt;
    logic                   own_r, own_nxt, pend_r, pend_nxt;
    logic [`PBP_BYTE_W+1:0] pendData_r, pendData_nxt;
    logic [1:0]             opCnt_r, opCnt_nxt, hiAddr_r, hiAddr_nxt;
    logic [`PBP_CTL_W-1:0]  status_r, status_nxt;

    logic isLegacy, isBuffered, isAddressed, isSlave, isMaster;
    logic csAct, rdAct, wrAct, wrCommit, rdCommit, fifoReady;
    pbp_sel_t selNow;

    always_comb begin
        // Config is only taken while the port is off, so a live port never sees a half-written setup
        on_nxt    = portControl[`PBP_CTL_ON_BIT];
        mode_nxt  = on_r ? mode_r  : portMode[`PBP_MODE_MODE_MSB:`PBP_MODE_MODE_LSB];
        address_increment_field_nxt  = on_r ? address_increment_field_r  : portMode[`PBP_MODE_ADDRESS_INCREMENT_FIELD_MSB:`PBP_MODE_ADDRESS_INCREMENT_FIELD_LSB];
        irqm_nxt  = on_r ? irqm_r  : portMode[`PBP_MODE_IRQM_MSB:`PBP_MODE_IRQM_LSB];
        csf_nxt   = on_r ? csf_r   : portControl[`PBP_CTL_CSF_MSB:`PBP_CTL_CSF_LSB];
        rdPol_nxt = on_r ? rdPol_r : portControl[`PBP_CTL_RDPOL_BIT];
        wrPol_nxt = on_r ? wrPol_r : portControl[`PBP_CTL_WRPOL_BIT];
        csPol_nxt = on_r ? csPol_r : portControl[`PBP_CTL_CS1POL_BIT];

        isLegacy    = (mode_r == `PBP_MODE_LEGACY) && (address_increment_field_r != `PBP_ADDRESS_INCREMENT_FIELD_BUFFERED);
        isBuffered  = (mode_r == `PBP_MODE_LEGACY) && (address_increment_field_r == `PBP_ADDRESS_INCREMENT_FIELD_BUFFERED);
        isAddressed = (mode_r == `PBP_MODE_ADDRESSED);
        isSlave     = on_r && (isLegacy || isBuffered || isAddressed);
        isMaster    = on_r && !isSlave;

        // Polarity 1 means active high
        csAct = isSlave && (csS2_r ~^ csPol_r);
        rdAct = csAct && (rdS2_r ~^ rdPol_r);
        wrAct = csAct && (wrS2_r ~^ wrPol_r);

        // Buffer pick at access start
        selNow = isAddressed ? adS2_r : (isBuffered ? wrPtr_r : `PBP_BUF_FIRST);
        if (isBuffered && !wrAct) begin
            selNow = rdPtr_r;
        end

        state_nxt   = state_r;
        accSel_nxt  = accSel_r;
        wrByte_nxt  = wrByte_r;
        rdPtr_nxt   = rdPtr_r;
        wrPtr_nxt   = wrPtr_r;
        inData_nxt  = inData_r;
        wrCommit    = 1'b0;
        rdCommit    = 1'b0;
        unique case (state_r)
            PBP_IDLE: begin
                if (wrAct) begin
                    state_nxt  = PBP_WRITE;
                    accSel_nxt = selNow;
                end else if (rdAct) begin
                    state_nxt  = PBP_READ;
                    accSel_nxt = selNow;
                end
            end
            PBP_WRITE: begin
                if (wrAct) begin
                    wrByte_nxt = dS2_r;
                end else begin
                    wrCommit  = 1'b1;
                    state_nxt = PBP_IDLE;
                end
            end
            PBP_READ: begin
                if (!rdAct) begin
                    rdCommit  = 1'b1;
                    state_nxt = PBP_IDLE;
                end
            end
        endcase

        if (wrCommit) begin
            inData_nxt[accSel_r*`PBP_BYTE_W +: `PBP_BYTE_W] = wrByte_r;
            if (isBuffered) begin
                wrPtr_nxt = wrPtr_r + `PBP_BUF_STEP;
            end
        end
        if (rdCommit && isBuffered) begin
            rdPtr_nxt = rdPtr_r + `PBP_BUF_STEP;
        end

        oe_nxt      = (state_nxt == PBP_READ);
        dataOut_nxt = outputDataRegister[accSel_nxt*`PBP_BYTE_W +: `PBP_BYTE_W];
        intFlag_nxt = (wrCommit || rdCommit)
                      && (isLegacy || irqm_r != `PBP_IRQM_BUF3 || accSel_r == `PBP_BUF_LAST);

        // Written byte waits here while the stream side stalls
        pend_nxt     = wrCommit || (pend_r && !fifoReady);
        pendData_nxt = wrCommit ? {accSel_r, wrByte_r} : pendData_r;
        ovf_nxt      = ovf_r || (wrCommit && pend_r && !fifoReady);

        own_nxt = isSlave;

        // Master op: busy for all but its last cycle
        opCnt_nxt = (opCnt_r != '0) ? opCnt_r - `PBP_OP_STEP : opCnt_r;
        if (isMaster && masterStart && opCnt_r == '0) begin
            opCnt_nxt = `PBP_MASTER_OP_CYC - `PBP_OP_STEP;
        end
        hiAddr_nxt = isMaster ? (masterAddrHigh & ~csf_r) : 2'h0;

        status_nxt = portMode;
        status_nxt[`PBP_MODE_BUSY_BIT] = (opCnt_nxt != '0);
    end

    always_ff @(posedge ref_clk) begin
        // Off port keeps only its config registers
        if (rst || !on_r) begin
            state_r    <= PBP_IDLE;
            accSel_r   <= `PBP_BUF_FIRST;
            rdPtr_r    <= `PBP_BUF_FIRST;
            wrPtr_r    <= `PBP_BUF_FIRST;
            wrByte_r   <= '0;
            inData_r   <= '0;
            dataOut_r  <= '0;
            oe_r       <= 1'b0;
            intFlag_r  <= 1'b0;
            ovf_r      <= 1'b0;
            pend_r     <= 1'b0;
            pendData_r <= '0;
            own_r      <= 1'b0;
            opCnt_r    <= '0;
            hiAddr_r   <= 2'h0;
            status_r   <= '0;
        end else begin
            state_r    <= state_nxt;
            accSel_r   <= accSel_nxt;
            rdPtr_r    <= rdPtr_nxt;
            wrPtr_r    <= wrPtr_nxt;
            wrByte_r   <= wrByte_nxt;
            inData_r   <= inData_nxt;
            dataOut_r  <= dataOut_nxt;
            oe_r       <= oe_nxt;
            intFlag_r  <= intFlag_nxt;
            ovf_r      <= ovf_nxt;
            pend_r     <= pend_nxt;
            pendData_r <= pendData_nxt;
            own_r      <= own_nxt;
            opCnt_r    <= opCnt_nxt;
            hiAddr_r   <= hiAddr_nxt;
            status_r   <= status_nxt;
        end
        if (rst) begin
            on_r    <= 1'b0;
            mode_r  <= `PBP_MODE_LEGACY;
            address_increment_field_r  <= 2'h0;
            irqm_r  <= 2'h0;
            csf_r   <= 2'h0;
            rdPol_r <= 1'b0;
            wrPol_r <= 1'b0;
            csPol_r <= 1'b0;
        end else begin
            on_r    <= on_nxt;
            mode_r  <= mode_nxt;
            address_increment_field_r  <= address_increment_field_nxt;
            irqm_r  <= irqm_nxt;
            csf_r   <= csf_nxt;
            rdPol_r <= rdPol_nxt;
            wrPol_r <= wrPol_nxt;
            csPol_r <= csPol_nxt;
        end
    end

    // ----------------------------------------
    // Received byte stream
    // ----------------------------------------
    pbp_fifo #(
        .WIDTH (`PBP_BYTE_W + 2),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .ref_clk  (ref_clk),
        .rst      (rst || !on_r),
        .inValid  (pend_r),
        .inReady  (fifoReady),
        .inData   (pendData_r),
        .outValid (rxValid),
        .outReady (rxReady),
        .outData  (rxData)
    );

    assign modeStatus        = status_r;
    assign portDataOut       = dataOut_r;
    assign portDataOe        = oe_r;
    assign slaveOwnsPins     = own_r;
    assign highAddressOut    = hiAddr_r;
    assign inputDataRegister = inData_r;
    assign portInterruptFlag = intFlag_r;
    assign writeOverflow     = ovf_r;
    assign accessState       = state_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    drive_on_read_a: assert property (oe_r |-> $past(rdAct))
        else $error("data driven without select and read");
    off_releases_a: assert property (!on_r |=> !oe_r && !own_r && !portInterruptFlag)
        else $error("port active while off");
    wptr_wrap_a: assert property (wrCommit && isBuffered && wrPtr_r == `PBP_BUF_LAST && on_nxt
                                  |=> wrPtr_r == `PBP_BUF_FIRST)
        else $error("write pointer did not wrap");
    legacy_byte_zero_a: assert property (wrCommit && isLegacy && on_nxt
                                         |=> inData_r[`PBP_WORD_W-1:`PBP_BYTE_W]
                                             == $past(inData_r[`PBP_WORD_W-1:`PBP_BYTE_W]))
        else $error("legacy write touched upper bytes");
    addr_byte_two_a: assert property (wrCommit && isAddressed && accSel_r == 2'h2 && on_nxt
                                      |=> inData_r[23:16] == $past(wrByte_r))
        else $error("address 2 did not land in buffer 2");
    busy_length_a: assert property ($rose(status_r[`PBP_MODE_BUSY_BIT]) && on_r
                                    |-> status_r[`PBP_MODE_BUSY_BIT] [*2] ##1 !status_r[`PBP_MODE_BUSY_BIT])
        else $error("busy length wrong");
    busy_ignores_a: assert property (opCnt_r != '0 && on_nxt |=> opCnt_r == $past(opCnt_r) - `PBP_OP_STEP)
        else $error("start accepted while busy");
    buf3_irq_a: assert property (intFlag_r && irqm_r == `PBP_IRQM_BUF3 && !isLegacy
                                 |-> $past(accSel_r) == `PBP_BUF_LAST)
        else $error("interrupt outside buffer 3");
    pins_owned_a: assert property (on_r && $past(on_r) |-> own_r == $past(isSlave))
        else $error("pin ownership does not follow mode");

    legacy_write_c: cover property (wrCommit && isLegacy);
    buffered_read_c: cover property (rdCommit && isBuffered && rdPtr_r == `PBP_BUF_LAST);
    addr_write_c: cover property (wrCommit && isAddressed && accSel_r == `PBP_BUF_LAST);
    master_op_c: cover property ($fell(status_r[`PBP_MODE_BUSY_BIT]));

endmodule : pbp_slave_port

// ===== test/pbp_ext_master.sv
`timescale 1ns/1ns

// ----------------------------------------
// External master driving strobes and data
// ----------------------------------------
module pbp_ext_master (
    // Clock
    input  wire logic       ref_clk,
    // Pin polarity: bit0 read, bit1 write, bit2 select
    input  wire logic [2:0] pinPolarity,
    // Device answer
    input  wire logic [7:0] devData,
    input  wire logic       devOe,
    // Master pins
    output logic            chipSelectOne,
    output logic            readStrobe,
    output logic            writeStrobe,
    output logic [1:0]      portAddressLines,
    output logic [7:0]      portDataIn
);
    logic csAct;
    logic rdAct;
    logic wrAct;

    assign chipSelectOne = ~(csAct ^ pinPolarity[2]);
    assign readStrobe    = ~(rdAct ^ pinPolarity[0]);
    assign writeStrobe   = ~(wrAct ^ pinPolarity[1]);

    initial begin
        csAct = 1'b0;
        rdAct = 1'b0;
        wrAct = 1'b0;
        portAddressLines = 2'h0;
        portDataIn = 8'h00;
    end

    // Strobe held 6 clocks, idle 5 clocks: above the 2 and 3 the syncs need
    task automatic access(input logic isWrite, input logic [1:0] addr, input logic [7:0] data,
                          output logic [7:0] rdata);
        @(posedge ref_clk) #1;
        portAddressLines = addr;
        portDataIn = isWrite ? data : ~portDataIn;
        csAct = 1'b1;
        rdAct = ~isWrite;
        wrAct = isWrite;
        repeat (6) @(posedge ref_clk);
        rdata = devOe ? devData : 8'hxx;
        #1;
        csAct = 1'b0;
        rdAct = 1'b0;
        wrAct = 1'b0;
        // Released lines show no stale value
        portDataIn = ~portDataIn;
        portAddressLines = ~portAddressLines;
        repeat (5) @(posedge ref_clk);
    endtask : access
endmodule : pbp_ext_master

// ===== test/parallel_slave_port_bench.sv
`timescale 1ns/1ns

module parallel_slave_port_bench;
    import pbp_pkg::*;

    logic        ref_clk, rst, portDataOe, slaveOwnsPins, portInterruptFlag, writeOverflow;
    logic        masterStart, rxValid, rxReady, chipSelectOne, readStrobe, writeStrobe;
    logic [15:0] portControl, portMode, modeStatus;
    logic [1:0]  portAddressLines, highAddressOut, masterAddrHigh;
    logic [7:0]  portDataIn, portDataOut, rdByte;
    logic [31:0] outputDataRegister, inputDataRegister, seed;
    logic [9:0]  rxData;
    logic [2:0]  pol;
    logic [7:0]  wd [0:18];
    pbp_acc_t    accessState;
    int          nMismatch, compares, cycles, nIrq, nBusy, i, p, n;

    pbp_slave_port #(.FIFO_DEPTH(16)) i_pbp_slave_port (
        .ref_clk(ref_clk), .rst(rst), .portControl(portControl), .portMode(portMode),
        .modeStatus(modeStatus), .chipSelectOne(chipSelectOne), .readStrobe(readStrobe),
        .writeStrobe(writeStrobe), .portAddressLines(portAddressLines), .portDataIn(portDataIn),
        .portDataOut(portDataOut), .portDataOe(portDataOe), .slaveOwnsPins(slaveOwnsPins),
        .highAddressOut(highAddressOut), .outputDataRegister(outputDataRegister),
        .inputDataRegister(inputDataRegister), .portInterruptFlag(portInterruptFlag),
        .writeOverflow(writeOverflow), .accessState(accessState), .masterStart(masterStart),
        .masterAddrHigh(masterAddrHigh), .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData));

    pbp_ext_master i_pbp_ext_master (
        .ref_clk(ref_clk), .pinPolarity(pol), .devData(portDataOut), .devOe(portDataOe),
        .chipSelectOne(chipSelectOne), .readStrobe(readStrobe), .writeStrobe(writeStrobe),
        .portAddressLines(portAddressLines), .portDataIn(portDataIn));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [7:0] byteOf(input logic [31:0] w, input int idx);
        return w[8*idx +: 8];
    endfunction : byteOf

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            nMismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Config only taken while off, so write it before setting on
    task automatic configure(input logic [15:0] c, input logic [15:0] m);
        @(posedge ref_clk) #1;
        portControl = c & 16'h7fff;
        portMode = m;
        // Pins flip polarity only while the port is off, so no false access
        pol = {c[3], c[1], c[0]};
        repeat (3) @(posedge ref_clk);
        #1 portControl = c | 16'h8000;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask : configure

    task automatic conclude();
        $display("counts: compares=%0d mismatches=%0d", compares, nMismatch);
        if (nMismatch == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    // ----------------------------------------
    // Clock, monitors, timeout
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (portInterruptFlag === 1'b1) nIrq++;
        if (modeStatus[15] === 1'b1) nBusy++;
        if (cycles == 6000) begin
            nMismatch++;
            conclude();
        end
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        portControl = 16'h0000;
        portMode = 16'h0000;
        outputDataRegister = 32'h0000_0000;
        masterStart = 1'b0;
        masterAddrHigh = 2'h0;
        rxReady = 1'b1;
        pol = 3'h0;
        seed = 32'h015e2095;
        repeat (8) @(posedge ref_clk);
        #1 rst = 1'b0;
        check(32'(accessState), 32'(PBP_IDLE));
        check(32'(portDataOe), 32'h0);
        // Legacy, every polarity; increment field must not matter
        for (p = 0; p < 8; p++) begin
            configure({12'h000, p[2], 1'b0, p[1], p[0]}, 16'h0800);
            check(32'(slaveOwnsPins), 32'h1);
            seed = lfsr(seed);
            outputDataRegister = seed;
            n = nIrq;
            i_pbp_ext_master.access(1'b1, p[1:0], seed[15:8], rdByte);
            check(32'(inputDataRegister[7:0]), 32'(seed[15:8]));
            i_pbp_ext_master.access(1'b0, p[1:0], 8'h00, rdByte);
            check(32'(rdByte), 32'(byteOf(outputDataRegister, 0)));
            check(32'(portDataOe), 32'h0);
            check(32'(nIrq - n), 32'h2);
        end
        $display("test legacy done");
        configure(16'h0000, 16'h1800);
        seed = lfsr(seed);
        outputDataRegister = seed;
        for (i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            wd[i] = seed[7:0];
            i_pbp_ext_master.access(1'b1, 2'h3, wd[i], rdByte);
        end
        check(inputDataRegister, {wd[3], wd[2], wd[1], wd[4]});
        for (i = 0; i < 5; i++) begin
            i_pbp_ext_master.access(1'b0, 2'h3, 8'h00, rdByte);
            check(32'(rdByte), 32'(byteOf(outputDataRegister, i % 4)));
        end
        $display("test buffered done");
        // Addressable, interrupt on buffer 3 only
        configure(16'h0000, 16'h4100);
        n = nIrq;
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            i_pbp_ext_master.access(1'b1, i[1:0], seed[7:0], rdByte);
            check(32'(byteOf(inputDataRegister, i)), 32'(seed[7:0]));
            i_pbp_ext_master.access(1'b0, i[1:0], 8'h00, rdByte);
            check(32'(rdByte), 32'(byteOf(outputDataRegister, i)));
        end
        check(32'(nIrq - n), 32'h2);
        $display("test addressable done");
        // Master op; second start while busy must be dropped
        configure(16'h0000, 16'h0200);
        check(32'(slaveOwnsPins), 32'h0);
        masterAddrHigh = 2'h2;
        nBusy = 0;
        masterStart = 1'b1;
        @(posedge ref_clk) #1 masterStart = 1'b0;
        for (i = 0; i < 5 && modeStatus[15] !== 1'b1; i++) begin
            @(posedge ref_clk) #1;
        end
        masterStart = 1'b1;
        @(posedge ref_clk) #1 masterStart = 1'b0;
        repeat (8) @(posedge ref_clk);
        check(32'(nBusy), 32'h2);
        check(32'(highAddressOut), 32'h2);
        check(32'(modeStatus), 32'h0200);
        $display("test master done");
        // Stream stalled until a byte is lost, then drained
        configure(16'h0000, 16'h0100);
        rxReady = 1'b0;
        // 17 queued plus one waiting; the 19th write replaces the waiting byte
        for (i = 0; i < 19; i++) begin
            seed = lfsr(seed);
            wd[i] = seed[7:0];
            i_pbp_ext_master.access(1'b1, i[1:0], wd[i], rdByte);
            if (i == 17) check(32'(writeOverflow), 32'h0);
        end
        check(32'(writeOverflow), 32'h1);
        #1 rxReady = 1'b1;
        n = 0;
        repeat (40) begin
            @(posedge ref_clk);
            if (rxValid === 1'b1 && n < 19) begin
                p = (n == 17) ? 18 : n;
                check(32'(rxData), 32'({p[1:0], wd[p]}));
                n++;
            end
        end
        check(32'(n), 32'h12);
        configure(16'h0000, 16'h0100);
        check(32'(writeOverflow), 32'h0);
        $display("test stream done");
        conclude();
    end
endmodule : parallel_slave_port_bench
